/* vam_defs.svh */
// Purpose: constants for the valve alert monitor
// Assumes: 16-bit signed readings, 0.1 % or 0.1 degC per count
// Notes: word index addresses on the plain register port
`ifndef VAM_DEFS_SVH
`define VAM_DEFS_SVH
`define VAM_CLK_HZ 20000000
`define VAM_TICK_US 1000
`define VAM_PRESS_FAIL_S 60
`define VAM_A_CTRL 5'h00
`define VAM_A_HI 5'h01
`define VAM_A_HIHI 5'h02
`define VAM_A_LO 5'h03
`define VAM_A_LOLO 5'h04
`define VAM_A_TDB 5'h05
`define VAM_A_CUTHI 5'h06
`define VAM_A_CUTLO 5'h07
`define VAM_A_DEVPT 5'h08
`define VAM_A_DEVTIME 5'h09
`define VAM_A_CYCDB 5'h0A
`define VAM_A_CYCALR 5'h0B
`define VAM_A_ACCALR 5'h0C
`define VAM_A_PALIM 5'h0D
`define VAM_A_SUPHI 5'h0E
`define VAM_A_SUPLO 5'h0F
`define VAM_A_LATCHTO 5'h10
`define VAM_A_STRKLIM 5'h11
`define VAM_A_BRKLIM 5'h12
`define VAM_A_SDMASK 5'h13
`define VAM_A_LOOPMIN 5'h14
`define VAM_A_LOOPMAX 5'h15
`define VAM_A_CYCCNT 5'h16
`define VAM_A_ACC 5'h17
`define VAM_A_STAT0 5'h18
`define VAM_A_STAT1 5'h19
`define VAM_A_STRKREC 5'h1A
`define VAM_A_BRKREC 5'h1B
`define VAM_A_CALREC 5'h1C
`define VAM_CFG_LAST 5'h15
`define VAM_CTRL_PA_ALERT 0
`define VAM_CTRL_PA_LIMIT 1
`define VAM_CTRL_LRESET 2
`define VAM_TRV_MIN 16'sh00FA
`define VAM_TRV_MAX 16'sh04E2
`define VAM_PRS_MIN 16'sh00F0
`define VAM_PRS_MAX 16'sh04E2
`define VAM_TMP_MIN 16'shFDA8
`define VAM_TMP_MAX 16'sh03E8
`define VAM_CFG_RST 16'h0000
`define VAM_S1_FAILED 0
`define VAM_S1_PASS 1
`define VAM_S1_ABN 2
`define VAM_S1_PROH 3
`define VAM_S1_PANEL 4
`define VAM_S1_MRR 5
`define VAM_S1_STRK 6
`endif

/* vam_pkg.sv */
// Purpose: types for the valve alert monitor
// Assumes: nothing
// Notes: one-hot codes written out
`default_nettype none
package vam_pkg;
   typedef enum logic [1:0] {
      VAM_RUN = 2'b01,
      VAM_TRIPPED = 2'b10
   } vam_trip_type;
   typedef enum logic [1:0] {
      VAM_UP = 2'b01,
      VAM_DOWN = 2'b10
   } vam_dir_type;
endpackage
`default_nettype wire

/* vam_monitor.sv */
// Purpose: valve positioner alert evaluation with register port
// Assumes: readings synchronous to clk, 0.1 % / 0.1 degC per count
// Notes: clk_en low freezes every flip-flop, register port included
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "vam_defs.svh"
`default_nettype none
// Operation
// - Pressure outside 24-125 % over 60 s
// - Travel outside 25-125 % raises fail
// - Temperature fail or outside -60..100 C
// - High travel alert with deadband clear
// - High-high travel alert with deadband clear
// - Low travel alert with deadband clear
// - High cutoff flag, no hysteresis
// - Low cutoff flag, no hysteresis
// - Timed deviation alert, deadband clear
// - Reversal beyond deadband counts, accumulates travel
// - Accumulator alert; host clears by rewrite
// - Cycle count alert; host clears by rewrite
// - Port A overpressure needs both enables
// - Supply pressure high alert
// - Supply pressure low alert
// - Shutdown alert forces failed, output off
// - Stroke test pass flag times out
// - Panel trip flag clears after timeout
// - Tripped: manual reset required, ignore loop
// - Record stroke times, flag over threshold
// - Flag failed and prohibited stroke tests
// - Variable out of range alert
module vam_monitor #(
   parameter int TICK_CYCLES = `VAM_CLK_HZ / 1000000 * `VAM_TICK_US,
   parameter int PRESS_FAIL_MS = `VAM_PRESS_FAIL_S * 1000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [4:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [15:0] rd_data,
   input wire logic signed [15:0] travel,
   input wire logic signed [15:0] travel_target,
   input wire logic signed [15:0] press_a,
   input wire logic signed [15:0] press_b,
   input wire logic signed [15:0] press_supply,
   input wire logic signed [15:0] temperature,
   input wire logic temp_sensor_bad,
   input wire logic signed [15:0] loop_current,
   input wire logic reading_saturated,
   input wire logic single_acting_direct,
   input wire logic panel_trip_button,
   input wire logic panel_reset_button,
   input wire logic demand_trip,
   input wire logic valve_at_normal,
   input wire logic stroke_event,
   input wire logic [15:0] stroke_time,
   input wire logic [15:0] breakout_time,
   input wire logic [15:0] calendar_time,
   input wire logic partial_stroke_test_pass,
   input wire logic partial_stroke_test_fail,
   input wire logic partial_stroke_test_abort,
   output logic [15:0] alerts,
   output logic failed,
   output logic follow_loop,
   output logic manual_reset_required,
   output logic panel_tripped,
   output logic ptest_pass
);
   logic [15:0] cfg [0:`VAM_CFG_LAST];
   logic [15:0] cyc_count;
   logic [15:0] acc;
   logic [16:0] ms_div;
   logic [16:0] press_ms;
   logic [15:0] dev_ms;
   logic [15:0] panel_ms;
   logic [15:0] pass_ms;
   logic ptest_abn;
   logic ptest_proh;
   logic stroke_perf;
   logic [15:0] strk_rec;
   logic [15:0] brk_rec;
   logic [15:0] cal_rec;
   logic signed [15:0] cyc_ref;
   logic signed [15:0] cyc_ext;
   vam_pkg::vam_dir_type dir;
   vam_pkg::vam_trip_type trip_st;
   vam_pkg::vam_trip_type next_trip_st;

   // Register decode
   wire wr_cfg = wr_en && addr <= `VAM_CFG_LAST;
   wire wr_cyc = wr_en && addr == `VAM_A_CYCCNT;
   wire wr_acc = wr_en && addr == `VAM_A_ACC;
   wire wr_st1 = wr_en && addr == `VAM_A_STAT1;
   wire host_reset = wr_en && addr == `VAM_A_CTRL
      && wr_data[`VAM_CTRL_LRESET];
   wire tick = ms_div == 17'(TICK_CYCLES - 1);

   // Signed extension of config values
   wire signed [16:0] t = 17'(travel);
   wire signed [16:0] hi = 17'($signed(cfg[`VAM_A_HI]));
   wire signed [16:0] hihi = 17'($signed(cfg[`VAM_A_HIHI]));
   wire signed [16:0] lo = 17'($signed(cfg[`VAM_A_LO]));
   wire signed [16:0] lolo = 17'($signed(cfg[`VAM_A_LOLO]));
   wire signed [16:0] tdb = 17'($signed(cfg[`VAM_A_TDB]));
   wire signed [16:0] cdb = 17'($signed(cfg[`VAM_A_CYCDB]));
   wire signed [16:0] devpt = 17'($signed(cfg[`VAM_A_DEVPT]));
   wire signed [16:0] dev_raw = 17'(travel_target) - t;
   wire signed [16:0] dev_abs = dev_raw < 0 ? -dev_raw : dev_raw;

   // Sensor range checks
   wire prs_a_out = press_a < `VAM_PRS_MIN || press_a > `VAM_PRS_MAX;
   wire prs_b_out = press_b < `VAM_PRS_MIN || press_b > `VAM_PRS_MAX;
   wire prs_s_out = press_supply < `VAM_PRS_MIN
      || press_supply > `VAM_PRS_MAX;
   wire prs_out = prs_a_out || prs_b_out || prs_s_out;
   wire trv_out = travel < `VAM_TRV_MIN || travel > `VAM_TRV_MAX;
   wire tmp_out = temp_sensor_bad || temperature < `VAM_TMP_MIN
      || temperature > `VAM_TMP_MAX;
   wire loop_out = loop_current < $signed(cfg[`VAM_A_LOOPMIN])
      || loop_current > $signed(cfg[`VAM_A_LOOPMAX]);

   // Hysteresis: set at the point, clear a deadband back inside the point
   wire next_hi = alerts[3] ? !(t < hi - tdb) : t > hi;
   wire next_hihi = alerts[4] ? !(t < hihi - tdb) : t > hihi;
   wire next_lo = alerts[5] ? !(t > lo + tdb) : t < lo;
   wire next_lolo = alerts[6] ? !(t > lolo + tdb) : t < lolo;
   wire dev_over = dev_abs > devpt;
   wire next_dev = alerts[9] ? !(dev_abs < devpt - tdb)
      : dev_over && dev_ms > cfg[`VAM_A_DEVTIME];
   wire pa_armed = cfg[`VAM_A_CTRL][`VAM_CTRL_PA_ALERT]
      && cfg[`VAM_A_CTRL][`VAM_CTRL_PA_LIMIT] && single_acting_direct;

   // Reversal counts only once travel leaves the deadband
   wire signed [16:0] ext = 17'(cyc_ext);
   wire signed [16:0] ref_pt = 17'(cyc_ref);
   wire signed [16:0] span_raw = ext - ref_pt;
   wire signed [16:0] span = span_raw < 0 ? -span_raw : span_raw;
   wire up = dir == vam_pkg::VAM_UP;
   wire extend = up ? t > ext : t < ext;
   wire back = up ? ext - t > cdb : t - ext > cdb;
   wire reversal = !extend && back && span > cdb;
   wire [15:0] cyc_base = wr_cyc ? wr_data : cyc_count;
   wire [15:0] acc_base = wr_acc ? wr_data : acc;
   wire [15:0] next_cyc = reversal ? cyc_base + 16'h0001 : cyc_base;
   wire [15:0] next_acc = reversal ? acc_base + span[15:0] : acc_base;

   wire [15:0] next_alerts = {
      prs_out || trv_out || tmp_out || loop_out || reading_saturated,
      press_supply < $signed(cfg[`VAM_A_SUPLO]),
      press_supply > $signed(cfg[`VAM_A_SUPHI]),
      pa_armed && press_a > $signed(cfg[`VAM_A_PALIM]),
      cyc_count > cfg[`VAM_A_CYCALR],
      acc > cfg[`VAM_A_ACCALR],
      next_dev,
      travel < $signed(cfg[`VAM_A_CUTLO]),
      travel > $signed(cfg[`VAM_A_CUTHI]),
      next_lolo, next_lo, next_hihi, next_hi,
      tmp_out, trv_out,
      press_ms > 17'(PRESS_FAIL_MS)
   };
   wire shutdown_hit = |(alerts & cfg[`VAM_A_SDMASK]);

   // Trip sequencing
   wire any_trip = panel_trip_button || demand_trip;
   wire any_reset = panel_reset_button || host_reset;
   always_comb begin
      case (trip_st)
         vam_pkg::VAM_RUN: next_trip_st = any_trip
            ? vam_pkg::VAM_TRIPPED : vam_pkg::VAM_RUN;
         vam_pkg::VAM_TRIPPED: next_trip_st = any_reset && !any_trip
            ? vam_pkg::VAM_RUN : vam_pkg::VAM_TRIPPED;
         default: next_trip_st = vam_pkg::VAM_TRIPPED;
      endcase
   end
   // Zero timeout must still wait for normal and run
   wire panel_clock_on = panel_tripped && valve_at_normal
      && trip_st == vam_pkg::VAM_RUN;
   wire latch_done_panel = tick && panel_clock_on
      && panel_ms >= cfg[`VAM_A_LATCHTO];
   wire latch_done_pass = tick && pass_ms >= cfg[`VAM_A_LATCHTO];
   wire strk_over = stroke_time > cfg[`VAM_A_STRKLIM]
      || breakout_time > cfg[`VAM_A_BRKLIM];

   wire [15:0] stat1 = {9'h000, stroke_perf, manual_reset_required,
      panel_tripped, ptest_proh, ptest_abn, ptest_pass, failed};
   wire [15:0] rd_mux = addr <= `VAM_CFG_LAST ? cfg[addr]
      : addr == `VAM_A_CYCCNT ? cyc_count
      : addr == `VAM_A_ACC ? acc
      : addr == `VAM_A_STAT0 ? alerts
      : addr == `VAM_A_STAT1 ? stat1
      : addr == `VAM_A_STRKREC ? strk_rec
      : addr == `VAM_A_BRKREC ? brk_rec
      : addr == `VAM_A_CALREC ? cal_rec : 16'h0000;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i <= `VAM_CFG_LAST; i++) cfg[i] <= `VAM_CFG_RST;
         rd_data <= 16'h0000;
      end else if (clk_en) begin
         if (wr_cfg) cfg[addr] <= wr_data;
         rd_data <= rd_en ? rd_mux : 16'h0000;
      end
   end

   // Millisecond timers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_div <= 17'h00000;
         press_ms <= 17'h00000;
         dev_ms <= 16'h0000;
      end else if (clk_en) begin
         ms_div <= tick ? 17'h00000 : ms_div + 17'h00001;
         if (!prs_out) press_ms <= 17'h00000;
         else if (tick && press_ms <= 17'(PRESS_FAIL_MS))
            press_ms <= press_ms + 17'h00001;
         if (!dev_over) dev_ms <= 16'h0000;
         else if (tick && dev_ms != 16'hFFFF)
            dev_ms <= dev_ms + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) alerts <= 16'h0000;
      else if (clk_en) alerts <= next_alerts;
   end

   // Cycle counter and accumulator; host write plus a reversal both land
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cyc_count <= 16'h0000;
         acc <= 16'h0000;
         cyc_ref <= 16'sh0000;
         cyc_ext <= 16'sh0000;
         dir <= vam_pkg::VAM_UP;
      end else if (clk_en) begin
         cyc_count <= next_cyc;
         acc <= next_acc;
         if (extend) cyc_ext <= travel;
         else if (reversal) begin
            cyc_ref <= cyc_ext;
            cyc_ext <= travel;
            dir <= up ? vam_pkg::VAM_DOWN : vam_pkg::VAM_UP;
         end
      end
   end

   // Trip, latches and stroke test flags; a set beats a clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trip_st <= vam_pkg::VAM_RUN;
         failed <= 1'b0;
         panel_tripped <= 1'b0;
         panel_ms <= 16'h0000;
         ptest_pass <= 1'b0;
         pass_ms <= 16'h0000;
         ptest_abn <= 1'b0;
         ptest_proh <= 1'b0;
      end else if (clk_en) begin
         trip_st <= next_trip_st;
         if (shutdown_hit) failed <= 1'b1;
         else if (any_reset) failed <= 1'b0;
         if (panel_trip_button) panel_tripped <= 1'b1;
         else if (latch_done_panel) panel_tripped <= 1'b0;
         if (!panel_tripped || !valve_at_normal
             || trip_st == vam_pkg::VAM_TRIPPED)
            panel_ms <= 16'h0000;
         else if (tick) panel_ms <= panel_ms + 16'h0001;
         if (partial_stroke_test_pass) ptest_pass <= 1'b1;
         else if (latch_done_pass) ptest_pass <= 1'b0;
         if (!ptest_pass || partial_stroke_test_pass) pass_ms <= 16'h0000;
         else if (tick) pass_ms <= pass_ms + 16'h0001;
         if (partial_stroke_test_fail) ptest_abn <= 1'b1;
         else if (wr_st1 && wr_data[`VAM_S1_ABN]) ptest_abn <= 1'b0;
         if (partial_stroke_test_abort) ptest_proh <= 1'b1;
         else if (wr_st1 && wr_data[`VAM_S1_PROH]) ptest_proh <= 1'b0;
      end
   end

   // Stroke performance record
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strk_rec <= 16'h0000;
         brk_rec <= 16'h0000;
         cal_rec <= 16'h0000;
         stroke_perf <= 1'b0;
      end else if (clk_en) begin
         if (stroke_event) begin
            strk_rec <= stroke_time;
            brk_rec <= breakout_time;
            cal_rec <= calendar_time;
         end
         if (stroke_event && strk_over) stroke_perf <= 1'b1;
         else if (wr_st1 && wr_data[`VAM_S1_STRK]) stroke_perf <= 1'b0;
      end
   end

   assign manual_reset_required = trip_st == vam_pkg::VAM_TRIPPED;
   // Loop signal ignored while tripped or failed
   assign follow_loop = !manual_reset_required && !failed;

   default clocking vam_cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_travel_fail_range: assert property (
      clk_en && trv_out |=> alerts[1])
      else $error("travel fail alert missing");
   a_temp_fail_range: assert property (
      clk_en && (temperature > `VAM_TMP_MAX) |=> alerts[2])
      else $error("temperature fail alert missing");
   a_high_alert_hold: assert property (
      clk_en && alerts[3] && !(t < hi - tdb) |=> alerts[3])
      else $error("high alert dropped inside deadband");
   a_lowlow_own_point: assert property (
      clk_en && !alerts[6] && t >= lolo |=> !alerts[6])
      else $error("low-low set above its point");
   a_cutoff_high_flag: assert property (
      clk_en |=> alerts[7] == $past(travel > $signed(cfg[`VAM_A_CUTHI])))
      else $error("high cutoff flag wrong");
   a_port_a_gate: assert property (
      clk_en && !pa_armed |=> !alerts[12])
      else $error("port A alert while disarmed");
   a_supply_low_flag: assert property (
      clk_en && press_supply < $signed(cfg[`VAM_A_SUPLO]) |=> alerts[14])
      else $error("supply low alert missing");
   a_shutdown_fails: assert property (
      clk_en && shutdown_hit |=> failed && !follow_loop)
      else $error("shutdown did not fail device");
   sequence s_trip_req;
      clk_en && any_trip;
   endsequence
   sequence s_held_tripped;
      manual_reset_required && !follow_loop;
   endsequence
   a_trip_manual_reset: assert property (
      s_trip_req |=> s_held_tripped)
      else $error("trip did not require manual reset");
   a_reversal_counts: assert property (
      clk_en && reversal && !wr_cyc |=> cyc_count == $past(cyc_count)
         + 16'h0001)
      else $error("reversal not counted");
   a_press_fail_clear: assert property (
      clk_en && !prs_out ##1 clk_en |=> !alerts[0])
      else $error("pressure fail without cause");
   a_hihi_set_point: assert property (
      clk_en && !alerts[4] && t > hihi |=> alerts[4])
      else $error("high-high alert missing");
   a_low_set_point: assert property (
      clk_en && !alerts[5] && t < lo |=> alerts[5])
      else $error("low alert missing");
   a_cutoff_low_flag: assert property (
      clk_en |=> alerts[8] == $past(travel < $signed(cfg[`VAM_A_CUTLO])))
      else $error("low cutoff flag wrong");
   a_dev_needs_time: assert property (
      clk_en && !alerts[9] && dev_ms == 16'h0000 |=> !alerts[9])
      else $error("deviation alert too early");
   a_acc_alert_level: assert property (
      clk_en |=> alerts[10] == ($past(acc) > $past(cfg[`VAM_A_ACCALR])))
      else $error("accumulator alert wrong");
   a_cyc_alert_level: assert property (
      clk_en |=> alerts[11] == ($past(cyc_count) > $past(cfg[`VAM_A_CYCALR])))
      else $error("cycle alert wrong");
   a_supply_high_flag: assert property (
      clk_en && press_supply > $signed(cfg[`VAM_A_SUPHI]) |=> alerts[13])
      else $error("supply high alert missing");
   a_pass_flag_set: assert property (
      clk_en && partial_stroke_test_pass |=> ptest_pass)
      else $error("pass flag missing");
   a_panel_flag_hold: assert property (
      clk_en && panel_tripped && !valve_at_normal |=> panel_tripped)
      else $error("panel flag cleared off normal");
   a_stroke_record: assert property (
      clk_en && stroke_event |=> strk_rec == $past(stroke_time))
      else $error("stroke time not recorded");
   a_test_fail_flag: assert property (
      clk_en && partial_stroke_test_fail |=> ptest_abn)
      else $error("abnormal test flag missing");
   a_range_alert: assert property (
      clk_en && reading_saturated |=> alerts[15])
      else $error("out of range alert missing");
endmodule // vam_monitor
`default_nettype wire

/* vam_host.sv */
// Purpose: host model on the alert monitor register port
// Assumes: one-cycle strobes, read data stands in the following cycle
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ns
`include "vam_defs.svh"
`default_nettype none
module vam_host (
   input wire logic clk,
   output logic [4:0] addr,
   output logic [15:0] wr_data,
   output logic wr_en,
   output logic rd_en,
   input wire logic [15:0] rd_data
);
   initial begin
      addr = 5'h00;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end
   // Count, accumulator and latch reset all go through this write
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      addr <= ~a;
      wr_data <= ~d;
   endtask
   task automatic latch_reset(input logic [15:0] ctrl);
      wr(`VAM_A_CTRL, ctrl | 16'h0004);
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      d = rd_data;
   endtask
endmodule // vam_host
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the valve alert monitor
// Assumes: tick of 4 cycles and pressure fail after 6 ticks
// Notes: target follows travel except in the deviation case
`timescale 1ns/1ns
`include "vam_defs.svh"
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] addr;
   logic [15:0] wr_data, rd_data, alerts, rv, c1, a1;
   logic wr_en, rd_en, failed, follow_loop, manual_reset_required;
   logic panel_tripped, ptest_pass, temp_sensor_bad, reading_saturated;
   logic single_acting_direct, valve_at_normal;
   logic signed [15:0] travel, travel_target, press_a, press_b;
   logic signed [15:0] press_supply, temperature, loop_current;
   logic [15:0] stroke_time, breakout_time, calendar_time;
   logic [6:0] pls = 7'h00;
   wire panel_trip_button = pls[0];
   wire panel_reset_button = pls[1];
   wire demand_trip = pls[2];
   wire stroke_event = pls[3];
   int error_cnt = 0;
   int total_checks = 0;
   logic [15:0] cfg [0:21] = '{16'h0000, 16'h0320, 16'h0384, 16'h012C,
      16'h0118, 16'h0014, 16'h03B6, 16'h0104, 16'h0032, 16'h0003, 16'h0064,
      16'h7FFF, 16'h7FFF, 16'h03E8, 16'h044C, 16'h012C, 16'h0003, 16'h0064,
      16'h0064, 16'h0000, 16'h0000, 16'h03E8};
   logic [15:0] tv [0:15] = '{16'h032A, 16'h0316, 16'h0302, 16'h038E,
      16'h03C0, 16'h01F4, 16'h0122, 16'h0136, 16'h010E, 16'h0127, 16'h0131,
      16'h00FF, 16'h00F0, 16'h014A, 16'h0514, 16'h01F4};
   logic [15:0] te [0:15] = '{16'h0008, 16'h0008, 16'h0000, 16'h0018,
      16'h0098, 16'h0000, 16'h0020, 16'h0020, 16'h0060, 16'h0060, 16'h0020,
      16'h0160, 16'h0162, 16'h0000, 16'h009A, 16'h0000};
   vam_host u_host (.clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
   vam_monitor #(.TICK_CYCLES(4), .PRESS_FAIL_MS(5)) u_dut (.clk, .arst_n,
      .clk_en(1'b1), .addr, .wr_data, .wr_en, .rd_en, .rd_data, .travel,
      .travel_target, .press_a, .press_b, .press_supply, .temperature,
      .temp_sensor_bad, .loop_current, .reading_saturated,
      .single_acting_direct, .panel_trip_button, .panel_reset_button,
      .demand_trip, .valve_at_normal, .stroke_event, .stroke_time,
      .breakout_time, .calendar_time, .partial_stroke_test_pass(pls[4]),
      .partial_stroke_test_fail(pls[5]), .partial_stroke_test_abort(pls[6]),
      .alerts, .failed, .follow_loop, .manual_reset_required, .panel_tripped,
      .ptest_pass);
   always #25 clk = ~clk;
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Range alert masked by default: its travel and pressure reach is open
   task automatic ca(input logic [15:0] exp, input logic [15:0] m = 16'h7FFF);
      repeat (3) @(posedge clk);
      chk("alerts", exp, alerts & m);
   endtask
   task automatic mv(input logic [15:0] v);
      @(posedge clk);
      travel <= v;
      travel_target <= v;
      repeat (3) @(posedge clk);
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      pls[b] <= 1'b1;
      @(posedge clk);
      pls[b] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_regs;
      for (int i = 0; i <= 23; i++) begin
         u_host.rd(5'(i), rv);
         chk("reset value", 16'h0000, rv);
      end
      for (int i = 0; i <= 21; i++) begin
         u_host.wr(5'(i), cfg[i]);
      end
      for (int i = 0; i <= 21; i++) begin
         u_host.rd(5'(i), rv);
         chk("readback", cfg[i], rv);
      end
      u_host.wr(5'h1D, 16'hFFFF);
      u_host.wr(`VAM_A_STAT0, 16'hFFFF);
      u_host.rd(5'h1D, rv);
      chk("unmapped", 16'h0000, rv);
      u_host.rd(`VAM_A_STAT0, rv);
      chk("alert word", 16'h0000, rv);
      @(posedge clk);
      chk("idle read data", 16'h0000, rd_data);
   endtask
   task automatic t_travel;
      for (int i = 0; i <= 15; i++) begin
         mv(tv[i]);
         chk("trv", te[i], alerts & 16'h7FFF);
      end
   endtask
   task automatic t_dev;
      travel_target <= 16'h0258;
      repeat (6) @(posedge clk);
      chk("deviation early", 16'h0000, alerts & 16'h0200);
      repeat (30) @(posedge clk);
      chk("deviation set", 16'h0200, alerts & 16'h0200);
      travel_target <= 16'h0212;
      ca(16'h0200);
      travel_target <= 16'h0208;
      ca(16'h0000);
      travel_target <= 16'h01F4;
   endtask
   task automatic t_press;
      press_b <= 16'h00C8;
      repeat (8) @(posedge clk);
      chk("pressure early", 16'h0000, alerts & 16'h0001);
      repeat (40) @(posedge clk);
      chk("pressure fail", 16'h0001, alerts & 16'h0001);
      press_b <= 16'h01F4;
      ca(16'h0000);
      press_supply <= 16'h047E;
      ca(16'h2000);
      press_supply <= 16'h00FA;
      ca(16'h4000);
      press_supply <= 16'h01F4;
      press_a <= 16'h044C;
      ca(16'h0000);
      u_host.wr(`VAM_A_CTRL, 16'h0003);
      ca(16'h1000);
      single_acting_direct <= 1'b0;
      ca(16'h0000);
      single_acting_direct <= 1'b1;
      press_a <= 16'h01F4;
   endtask
   task automatic t_temp;
      temperature <= 16'hFDA3;
      ca(16'h0004);
      temperature <= 16'h03F2;
      ca(16'h0004);
      temperature <= 16'h00FA;
      temp_sensor_bad <= 1'b1;
      ca(16'h0004);
      temp_sensor_bad <= 1'b0;
      reading_saturated <= 1'b1;
      ca(16'h8000, 16'h8000);
      reading_saturated <= 1'b0;
      loop_current <= 16'h044C;
      ca(16'h8000, 16'h8000);
      loop_current <= 16'h01F4;
      ca(16'h0000, 16'hFFFF);
   endtask
   task automatic t_count;
      mv(16'h01F4);
      mv(16'h02BC);
      mv(16'h0226);
      u_host.rd(`VAM_A_CYCCNT, c1);
      u_host.rd(`VAM_A_ACC, a1);
      mv(16'h02EE);
      mv(16'h01F4);
      mv(16'h0230);
      mv(16'h01F4);
      u_host.rd(`VAM_A_CYCCNT, rv);
      chk("cycle count", c1 + 16'h0002, rv);
      u_host.rd(`VAM_A_ACC, rv);
      chk("accumulator", a1 + 16'h015E, rv);
      u_host.wr(`VAM_A_CYCCNT, 16'h0005);
      u_host.wr(`VAM_A_CYCALR, 16'h0004);
      ca(16'h0800);
      u_host.wr(`VAM_A_CYCCNT, 16'h0003);
      ca(16'h0000);
      u_host.wr(`VAM_A_ACC, 16'h03E8);
      u_host.wr(`VAM_A_ACCALR, 16'h0320);
      ca(16'h0400);
      u_host.wr(`VAM_A_ACC, 16'h0064);
      ca(16'h0000);
   endtask
   task automatic t_trip;
      pulse(2);
      chk("reset req", 16'h0001, {15'h0000, manual_reset_required});
      chk("loop ignored", 16'h0000, {15'h0000, follow_loop});
      pulse(1);
      chk("button reset", 16'h0001, {15'h0000, follow_loop});
      pulse(2);
      u_host.latch_reset(16'h0003);
      repeat (2) @(posedge clk);
      chk("host reset", 16'h0000, {15'h0000, manual_reset_required});
      valve_at_normal <= 1'b0;
      pulse(0);
      chk("panel flag", 16'h0001, {15'h0000, panel_tripped});
      pulse(1);
      repeat (30) @(posedge clk);
      chk("panel held", 16'h0001, {15'h0000, panel_tripped});
      valve_at_normal <= 1'b1;
      repeat (4) @(posedge clk);
      chk("panel early", 16'h0001, {15'h0000, panel_tripped});
      repeat (30) @(posedge clk);
      chk("panel cleared", 16'h0000, {15'h0000, panel_tripped});
   endtask
   task automatic t_stroke;
      pulse(4);
      repeat (3) @(posedge clk);
      chk("pass flag", 16'h0001, {15'h0000, ptest_pass});
      repeat (30) @(posedge clk);
      chk("pass timeout", 16'h0000, {15'h0000, ptest_pass});
      pulse(5);
      pulse(6);
      u_host.rd(`VAM_A_STAT1, rv);
      chk("test flags", 16'h000C, rv);
      u_host.wr(`VAM_A_STAT1, 16'h000C);
      stroke_time <= 16'h0096;
      breakout_time <= 16'h0032;
      calendar_time <= 16'h1234;
      pulse(3);
      u_host.rd(`VAM_A_STRKREC, rv);
      chk("stroke record", 16'h0096, rv);
      u_host.rd(`VAM_A_BRKREC, rv);
      chk("breakout record", 16'h0032, rv);
      u_host.rd(`VAM_A_CALREC, rv);
      chk("calendar record", 16'h1234, rv);
      u_host.rd(`VAM_A_STAT1, rv);
      chk("stroke alert", 16'h0040, rv);
   endtask
   task automatic t_fail;
      u_host.wr(`VAM_A_SDMASK, 16'h2000);
      press_supply <= 16'h047E;
      repeat (4) @(posedge clk);
      chk("failed", 16'h0001, {15'h0000, failed});
      chk("output off", 16'h0000, {15'h0000, follow_loop});
      press_supply <= 16'h01F4;
      repeat (4) @(posedge clk);
      chk("failed latched", 16'h0001, {15'h0000, failed});
      pulse(1);
      chk("failed reset", 16'h0000, {15'h0000, failed});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {travel, travel_target, press_a, press_b} = {4{16'h01F4}};
      {press_supply, loop_current} = {2{16'h01F4}};
      temperature = 16'h00FA;
      {stroke_time, breakout_time, calendar_time} = 48'h0;
      {temp_sensor_bad, reading_saturated} = 2'b00;
      {single_acting_direct, valve_at_normal} = 2'b11;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_travel();
      t_dev();
      t_press();
      t_temp();
      t_count();
      t_trip();
      t_stroke();
      t_fail();
      tally_and_finish();
   end
   // Guard against a hung handshake
   initial begin
      #1000000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
